// ### omc_ctrl.sv
// Purpose: control, status and memory answer logic of the pluggable optical module
// Assumes: byte accesses come pre-decoded from the two-wire slave on core_clk
// Notes: pins from the host pass two flip-flops before use
`timescale 1ns/100ps
module omc_ctrl (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // host pins, pull-up modeled as pin default
  input wire logic tx_off_pin,
  output logic tx_fault_o,
  output logic tx_fault_oe,
  output logic receive_signal_lost,
  // analog side
  input wire logic power_low,
  input wire logic power_high,
  input wire logic rx_signal_absent,
  input wire omc_pkg::omc_mon_s mon_in,
  output logic laser_en,
  // decoded two-wire byte access
  input wire logic req_valid,
  input wire omc_pkg::omc_req_s req,
  output logic rsp_valid,
  output logic [7:0] rsp_data
);
  logic [1:0] pin_sync_r;
  logic [1:0] pl_sync_r;
  logic [1:0] ph_sync_r;
  logic [1:0] los_sync_r;
  logic pin_prev_r;
  logic soft_off_r;
  logic fault_r;
  logic los_r;
  omc_pkg::omc_mon_s mon_r;
  logic [7:0] diag_mem [0:255];
  logic pin_off;
  logic tx_off;
  logic pin_toggle;
  logic fault_evt;
  logic [7:0] ctrl_byte;

  function automatic logic [7:0] mon_byte(input omc_pkg::omc_mon_s m, input logic [7:0] a);
    logic [7:0] r;
    logic [7:0] k;
    r = 8'h00;
    k = a - 8'(omc_pkg::MON_BIAS_OFS);
    case (k)
      8'h00: r = m.temp[15:8];
      8'h01: r = m.temp[7:0];
      8'h02: r = m.vcc[15:8];
      8'h03: r = m.vcc[7:0];
      8'h04: r = m.bias[15:8];
      8'h05: r = m.bias[7:0];
      8'h06: r = m.txpwr[15:8];
      8'h07: r = m.txpwr[7:0];
      8'h08: r = m.rxpwr[15:8];
      8'h09: r = m.rxpwr[7:0];
      default: r = 8'h00;
    endcase
    return r;
  endfunction

  // one decode of the control byte, shared by write, read and memory paths
  function automatic logic hits_ctrl(input omc_pkg::omc_req_s q);
    return q.sel_diag && (q.addr == omc_pkg::CTRL_STATUS_OFS);
  endfunction

  // reset forces pin synchronisers high: pull-up view until sampled
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_sync_r <= 2'h3;
      pin_prev_r <= 1'b1;
    end else begin
      pin_sync_r <= {pin_sync_r[0], tx_off_pin};
      pin_prev_r <= pin_sync_r[1];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pl_sync_r <= 2'h0;
      ph_sync_r <= 2'h0;
      los_sync_r <= 2'h0;
    end else begin
      pl_sync_r <= {pl_sync_r[0], power_low};
      ph_sync_r <= {ph_sync_r[0], power_high};
      los_sync_r <= {los_sync_r[0], rx_signal_absent};
    end
  end

  assign pin_off = pin_sync_r[1];
  // a low-to-high-to-low cycle; the falling edge re-enables, so clear on it
  assign pin_toggle = pin_prev_r & ~pin_off;
  assign fault_evt = pl_sync_r[1] | ph_sync_r[1];
  assign tx_off = pin_off | soft_off_r;

  // soft disable bit, only written by the two-wire master
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      soft_off_r <= omc_pkg::SOFT_OFF_RST;
    end else if (req_valid && req.wr && hits_ctrl(req)) begin
      soft_off_r <= req.wdata[omc_pkg::SOFT_OFF_BIT];
    end
  end

  // fault latch; a new fault wins over a simultaneous toggle clear
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_r <= 1'b0;
    end else if (fault_evt && !tx_off) begin
      fault_r <= 1'b1;
    end else if (pin_toggle) begin
      fault_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      los_r <= 1'b0;
    end else begin
      los_r <= los_sync_r[1];
    end
  end

  // monitor snapshot each cycle keeps readings current
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mon_r <= '0;
    end else begin
      mon_r <= mon_in;
    end
  end

  // diagnostic memory has no fixed content; loaded by diagnostic writes other than the control byte
  always_ff @(posedge core_clk) begin
    if (req_valid && req.wr && req.sel_diag && !hits_ctrl(req)) begin
      diag_mem[req.addr] <= req.wdata;
    end
  end

  assign laser_en = ~tx_off & ~fault_r;
  assign tx_fault_o = 1'b0;
  // open drain: drive low only when healthy, host pull-up gives high on fault
  assign tx_fault_oe = ~fault_r;
  assign receive_signal_lost = los_r;

  always_comb begin
    ctrl_byte = 8'h00;
    ctrl_byte[omc_pkg::PIN_OFF_BIT] = pin_off;
    ctrl_byte[omc_pkg::SOFT_OFF_BIT] = soft_off_r;
    ctrl_byte[omc_pkg::FAULT_BIT] = fault_r;
    ctrl_byte[omc_pkg::LOS_BIT] = los_r;
  end

  // read path: registered mux, nothing changes on a read
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rsp_valid <= 1'b0;
      rsp_data <= 8'h00;
    end else begin
      rsp_valid <= req_valid & ~req.wr;
      if (req_valid && !req.wr) begin
        if (!req.sel_diag) begin
          // identification contents lie outside this block; a fixed fill answers
          rsp_data <= omc_pkg::ID_FILL;
        end else if (hits_ctrl(req)) begin
          rsp_data <= ctrl_byte;
        end else if (req.addr >= 8'(omc_pkg::MON_BIAS_OFS)
                     && req.addr < 8'(omc_pkg::MON_BIAS_OFS + 2 * omc_pkg::MON_WORDS)) begin
          rsp_data <= mon_byte(mon_r, req.addr);
        end else begin
          rsp_data <= diag_mem[req.addr];
        end
      end
    end
  end

  // checked against the pin itself, so the sync path is covered too
  property p_tx_off;
    @(posedge core_clk) disable iff (!rst_n)
      $past(tx_off_pin, 2) || soft_off_r |-> !laser_en;
  endproperty
  a_tx_off: assert property (p_tx_off) else $error("laser on while disabled");

  property p_pin_sync;
    @(posedge core_clk) disable iff (!rst_n)
      tx_off_pin ##2 1 |-> ctrl_byte[omc_pkg::PIN_OFF_BIT] == $past(tx_off_pin, 2);
  endproperty
  a_pin_sync: assert property (p_pin_sync) else $error("mirror bit wrong");

  property p_fault_latch;
    @(posedge core_clk) disable iff (!rst_n) fault_r && !pin_toggle |=> fault_r;
  endproperty
  a_fault_latch: assert property (p_fault_latch) else $error("fault dropped");

  property p_fault_pin;
    @(posedge core_clk) disable iff (!rst_n) fault_r |-> !tx_fault_oe && !laser_en;
  endproperty
  a_fault_pin: assert property (p_fault_pin) else $error("fault not shown");

  property p_rd_noclear;
    @(posedge core_clk) disable iff (!rst_n)
      req_valid && !req.wr && fault_r && !pin_toggle |=> fault_r;
  endproperty
  a_rd_noclear: assert property (p_rd_noclear) else $error("read cleared fault");

  // a level held three samples has crossed both sync stages and the output register
  sequence s_los_held;
    rx_signal_absent ##1 rx_signal_absent ##1 rx_signal_absent;
  endsequence

  sequence s_los_gone;
    !rx_signal_absent ##1 !rx_signal_absent ##1 !rx_signal_absent;
  endsequence

  property p_los;
    @(posedge core_clk) disable iff (!rst_n) s_los_held |=> receive_signal_lost;
  endproperty
  a_los: assert property (p_los) else $error("loss not shown");

  property p_los_clear;
    @(posedge core_clk) disable iff (!rst_n) s_los_gone |=> !receive_signal_lost;
  endproperty
  a_los_clear: assert property (p_los_clear) else $error("loss stuck");

  property p_ctrl_rd;
    @(posedge core_clk) disable iff (!rst_n)
      req_valid && !req.wr && req.sel_diag && req.addr == omc_pkg::CTRL_STATUS_OFS
      |=> rsp_valid && rsp_data[omc_pkg::FAULT_BIT] == $past(fault_r)
          && rsp_data[omc_pkg::LOS_BIT] == $past(los_r)
          && rsp_data[omc_pkg::PIN_OFF_BIT] == $past(pin_off);
  endproperty
  a_ctrl_rd: assert property (p_ctrl_rd) else $error("status read wrong");

  property p_soft_wr;
    @(posedge core_clk) disable iff (!rst_n)
      req_valid && req.wr && req.sel_diag && req.addr == omc_pkg::CTRL_STATUS_OFS
      |=> soft_off_r == $past(req.wdata[omc_pkg::SOFT_OFF_BIT]);
  endproperty
  a_soft_wr: assert property (p_soft_wr) else $error("soft bit not written");

  property p_soft_keep;
    @(posedge core_clk) disable iff (!rst_n)
      !(req_valid && req.wr && req.sel_diag && req.addr == omc_pkg::CTRL_STATUS_OFS)
      |=> $stable(soft_off_r);
  endproperty
  a_soft_keep: assert property (p_soft_keep) else $error("soft bit moved");

  property p_pin_low;
    @(posedge core_clk) disable iff (!rst_n)
      !tx_off_pin ##2 1 |-> !ctrl_byte[omc_pkg::PIN_OFF_BIT];
  endproperty
  a_pin_low: assert property (p_pin_low) else $error("mirror bit stuck high");

  // power faults reach the latch two edges late, and only count while the laser may run
  sequence s_fault_seen;
    (power_low || power_high) ##2 !tx_off;
  endsequence

  property p_fault_set;
    @(posedge core_clk) disable iff (!rst_n) s_fault_seen |=> fault_r;
  endproperty
  a_fault_set: assert property (p_fault_set) else $error("fault not latched");

  // a high-to-low cycle of the pin reaches the clear two edges later
  sequence s_pin_fall;
    tx_off_pin ##1 !tx_off_pin ##2 !(fault_evt && !tx_off);
  endsequence

  property p_fault_clear;
    @(posedge core_clk) disable iff (!rst_n) s_pin_fall |=> !fault_r;
  endproperty
  a_fault_clear: assert property (p_fault_clear) else $error("fault not cleared");

  property p_rsp_read;
    @(posedge core_clk) disable iff (!rst_n) req_valid && !req.wr |=> rsp_valid;
  endproperty
  a_rsp_read: assert property (p_rsp_read) else $error("read not answered");

  property p_rsp_quiet;
    @(posedge core_clk) disable iff (!rst_n) !(req_valid && !req.wr) |=> !rsp_valid;
  endproperty
  a_rsp_quiet: assert property (p_rsp_quiet) else $error("answer without read");

  property p_id_read;
    @(posedge core_clk) disable iff (!rst_n)
      req_valid && !req.wr && !req.sel_diag |=> rsp_data == omc_pkg::ID_FILL;
  endproperty
  a_id_read: assert property (p_id_read) else $error("ident answer wrong");
endmodule

// ### omc_pkg.sv
// Purpose: shared constants and carriers for the module control and status logic
// Assumes: one 200 MHz core clock, two-wire slave decoded elsewhere into byte accesses
// Notes: identity values here are arbitrary
package omc_pkg;
  localparam logic [6:0] ID_DEV_ADDR = 7'h50;
  localparam logic [6:0] DIAG_DEV_ADDR = 7'h51;
  localparam logic [7:0] CTRL_STATUS_OFS = 8'h6E;
  localparam int SOFT_OFF_BIT = 6;
  localparam int PIN_OFF_BIT = 7;
  localparam int FAULT_BIT = 2;
  localparam int LOS_BIT = 1;
  localparam logic [7:0] CTRL_STATUS_WMASK = 8'h40;
  localparam logic SOFT_OFF_RST = 1'b0;
  localparam logic [7:0] ID_FILL = 8'h00;
  localparam int MON_BIAS_OFS = 96;
  localparam int MON_WORDS = 5;

  typedef struct packed {
    logic sel_diag;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } omc_req_s;

  typedef struct packed {
    logic [15:0] bias;
    logic [15:0] txpwr;
    logic [15:0] vcc;
    logic [15:0] temp;
    logic [15:0] rxpwr;
  } omc_mon_s;
endpackage

// ### omc_host.sv
// Purpose: host board model for the module control pins
// Assumes: host pull-ups on the transmit-off and fault lines
// Notes: a released line reads high, never its last driven value
`timescale 1ns/100ps
module omc_host (
  // bench control
  input wire logic drive_low,
  // module pins
  input wire logic tx_fault_o,
  input wire logic tx_fault_oe,
  output logic tx_off_line,
  output logic tx_fault_line
);
  // undriven pin floats high, so the laser stays off until the host pulls low
  assign tx_off_line = drive_low ? 1'b0 : 1'b1;
  // open-drain fault line, pull-up wins once the module lets go
  assign tx_fault_line = tx_fault_oe ? tx_fault_o : 1'b1;
endmodule

// ### optical_module_ctrl_status_bench.sv
// Purpose: self-checking bench for the module control and status logic
// Assumes: inputs change on the falling edge of core_clk
// Notes: status byte read through the decoded byte access port
`timescale 1ns/100ps
`define CHK(a, b) chk(a, b)
module optical_module_ctrl_status_bench;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic drive_low = 1'b0;
  logic power_low = 1'b0;
  logic power_high = 1'b0;
  logic rx_signal_absent = 1'b0;
  logic req_valid = 1'b0;
  omc_pkg::omc_req_s req = '0;
  omc_pkg::omc_mon_s mon_in = '0;
  logic tx_off_line, tx_fault_line, tx_fault_o, tx_fault_oe;
  logic receive_signal_lost, laser_en, rsp_valid;
  logic [7:0] rsp_data;
  logic [7:0] rd;
  int bad_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  always #2.5 core_clk = ~core_clk;
  omc_host u_host (.drive_low(drive_low), .tx_fault_o(tx_fault_o), .tx_fault_oe(tx_fault_oe),
    .tx_off_line(tx_off_line), .tx_fault_line(tx_fault_line));
  omc_ctrl u_dut (.core_clk(core_clk), .rst_n(rst_n), .tx_off_pin(tx_off_line),
    .tx_fault_o(tx_fault_o), .tx_fault_oe(tx_fault_oe), .receive_signal_lost(receive_signal_lost),
    .power_low(power_low), .power_high(power_high), .rx_signal_absent(rx_signal_absent),
    .mon_in(mon_in), .laser_en(laser_en), .req_valid(req_valid), .req(req),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // one access; a read answer stands only in the cycle after the taking edge
  task automatic acc(input logic d, input logic w, input logic [7:0] a, input logic [7:0] wd);
    @(negedge core_clk);
    req_valid = 1'b1;
    req = '{sel_diag: d, wr: w, addr: a, wdata: wd};
    @(negedge core_clk);
    req_valid = 1'b0;
    rd = rsp_data;
    if (!w) `CHK({7'h00, rsp_valid}, 8'h01);
  endtask
  task automatic rdst(input logic [7:0] exp);
    acc(1'b1, 1'b0, omc_pkg::CTRL_STATUS_OFS, 8'h00);
    `CHK(rd, exp);
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // hang guard, the whole sequence needs well under a thousand cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      wrap_up();
    end
  end
  initial begin
    wt(2);
    rst_n = 1'b1;
    wt(3);
    `CHK({7'h00, laser_en}, 8'h00);
    rdst(8'h80);
    drive_low = 1'b1;
    wt(4);
    `CHK({7'h00, laser_en}, 8'h01);
    `CHK({7'h00, tx_fault_line}, 8'h00);
    rdst(8'h00);
    // only bit 6 of the control byte is writable
    acc(1'b1, 1'b1, omc_pkg::CTRL_STATUS_OFS, 8'hFF);
    `CHK({7'h00, laser_en}, 8'h00);
    rdst(8'h40);
    acc(1'b1, 1'b1, omc_pkg::CTRL_STATUS_OFS, 8'h00);
    `CHK({7'h00, laser_en}, 8'h01);
    for (int k = 0; k < 2; k++) begin
      power_low = (k == 0);
      power_high = (k == 1);
      wt(4);
      power_low = 1'b0;
      power_high = 1'b0;
      wt(3);
      `CHK({7'h00, tx_fault_line}, 8'h01);
      `CHK({7'h00, laser_en}, 8'h00);
      rdst(8'h04);
      rdst(8'h04);
      drive_low = 1'b0;
      wt(4);
      drive_low = 1'b1;
      wt(5);
      `CHK({7'h00, tx_fault_line}, 8'h00);
      `CHK({7'h00, laser_en}, 8'h01);
    end
    rx_signal_absent = 1'b1;
    wt(4);
    `CHK({7'h00, receive_signal_lost}, 8'h01);
    rdst(8'h02);
    rx_signal_absent = 1'b0;
    wt(4);
    `CHK({7'h00, receive_signal_lost}, 8'h00);
    // identification memory ignores writes and answers apart from diagnostics
    acc(1'b0, 1'b1, 8'h10, 8'hAA);
    acc(1'b0, 1'b0, 8'h10, 8'h00);
    `CHK(rd, omc_pkg::ID_FILL);
    acc(1'b1, 1'b1, 8'h10, 8'h5A);
    acc(1'b1, 1'b0, 8'h10, 8'h00);
    `CHK(rd, 8'h5A);
    mon_in = '{bias: 16'h5566, txpwr: 16'h7788, vcc: 16'h3344, temp: 16'h1122, rxpwr: 16'h99AA};
    wt(2);
    for (int i = 0; i < 10; i++) begin
      acc(1'b1, 1'b0, 8'(omc_pkg::MON_BIAS_OFS + i), 8'h00);
      `CHK(rd, 8'(8'h11 * (i + 1)));
    end
    // second power cycle in mid-run clears the soft disable
    acc(1'b1, 1'b1, omc_pkg::CTRL_STATUS_OFS, 8'h40);
    rst_n = 1'b0;
    wt(1);
    rst_n = 1'b1;
    wt(4);
    rdst(8'h00);
    `CHK({7'h00, laser_en}, 8'h01);
    wrap_up();
  end
endmodule
